//--- emt_pkg.sv
// Package for the external encode measure trigger block.
// Assumes one 100 MHz clock and an external converter with start/done.
// Operation
// [RULE1] Front-edge and backplane lines start cycles; the code lets an open-collector line start one only where trig_enable is set
// [RULE2] Encode acts same as software trigger
// [RULE3] Input request returns the result
// [RULE4] Request during cycle waits for completion
// [RULE5] Any other command aborts the cycle
// [RULE6] Late request returns last trigger's result
// [RULE7] Repeated or held encode restarts cycles; the code ignores an encode edge during a cycle while a read is pending
// [RULE8] Only last started result is returned
// [RULE9] Interrupts only after arm command
// [RULE10] Interrupt when encode result is valid
// [RULE11] Controller polls manager for interrupt
// [RULE12] Backplane trigger lines active high
// [RULE13] Encode sources merged and synchronised
// [RULE14] Valid cleared on start/abort, set on done
package emt_pkg;
  localparam int unsigned RES_W = 24;
  localparam int unsigned FAST_N = 2;
  localparam int unsigned OC_N = 8;
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    EMT_CMD_NONE = 3'h0,
    EMT_CMD_GO = 3'h1,
    EMT_CMD_ARM = 3'h2,
    EMT_CMD_READ = 3'h3,
    EMT_CMD_OTHER = 3'h4
  } emt_cmd_type;

  typedef struct packed {
    logic valid;
    emt_cmd_type code;
  } emt_cmd_req_type;

  typedef struct packed {
    logic valid;
    logic [RES_W-1:0] data;
  } emt_result_type;

  typedef enum logic [1:0] {
    EMT_ST_IDLE = 2'b00,
    EMT_ST_RUN = 2'b01
  } emt_state_type;
endpackage

//--- emt_trigger_ctrl.sv
// External encode measure trigger control.
// Assumes converter answers conv_start with one conv.valid pulse; commands are one-cycle pulses.
`timescale 1ns/1ps
module emt_trigger_ctrl (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic front_encode_n,
  input wire logic [emt_pkg::FAST_N-1:0] backplane_fast_sync_line,
  input wire logic [emt_pkg::OC_N-1:0] backplane_open_collector_sync_line,
  input wire logic [emt_pkg::OC_N-1:0] trig_enable,
  input wire emt_pkg::emt_cmd_req_type cmd,
  input wire emt_pkg::emt_result_type conv,
  output logic conv_start,
  output logic conv_abort,
  output emt_pkg::emt_result_type reply,
  output logic irq
);
  import emt_pkg::*;

  localparam int unsigned SRC_W = 1 + FAST_N + OC_N;
  localparam logic [SRC_W-1:0] SYNC_IDLE = {1'b1, {(FAST_N + OC_N){1'b0}}};

  logic [SRC_W-1:0] raw;
  logic [SRC_W-1:0] s1_q;
  logic [SRC_W-1:0] s2_q;
  logic enc_lvl;
  logic enc_q;
  logic enc_ev;

  // Pins reach the synchroniser untouched
  assign raw = {front_encode_n, backplane_fast_sync_line, backplane_open_collector_sync_line};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
      enc_q <= 1'b0;
    end else begin
      s1_q <= raw; // [RULE13]
      s2_q <= s1_q;
      enc_q <= enc_lvl;
    end
  end

  // Front input active low, backplane lines active high
  assign enc_lvl = ~s2_q[SRC_W-1] | (|s2_q[SRC_W-2:OC_N])
                 | (|(s2_q[OC_N-1:0] & trig_enable)); // [RULE1] [RULE12] [RULE13]
  // Rising edge restarts a running cycle unless a read is pending; a held level starts again once idle
  assign enc_ev = enc_lvl & ~enc_q; // [RULE7]

  emt_state_type st_q, st_d;
  logic valid_q, valid_d;
  logic [RES_W-1:0] res_q, res_d;
  logic pend_q, pend_d;
  logic arm_q, arm_d;
  logic by_enc_q, by_enc_d;
  logic start_d, abort_d, irq_d;
  emt_result_type reply_d;
  logic go, other, rd_req;

  assign go = cmd.valid && cmd.code == EMT_CMD_GO;
  assign other = cmd.valid && cmd.code != EMT_CMD_READ && cmd.code != EMT_CMD_GO;
  assign rd_req = cmd.valid && cmd.code == EMT_CMD_READ;

  always_comb begin
    st_d = st_q;
    valid_d = valid_q;
    res_d = res_q;
    pend_d = pend_q;
    arm_d = arm_q;
    by_enc_d = by_enc_q;
    start_d = 1'b0;
    abort_d = 1'b0;
    irq_d = 1'b0;
    reply_d = '0;
    if (cmd.valid && cmd.code == EMT_CMD_ARM) begin
      arm_d = 1'b1; // [RULE9]
    end
    unique case (st_q)
      EMT_ST_IDLE: begin
        if (go || enc_lvl) begin
          st_d = EMT_ST_RUN; // [RULE2] [RULE7]
          start_d = 1'b1;
          valid_d = 1'b0; // [RULE14]
          by_enc_d = enc_lvl && !go;
        end
      end
      EMT_ST_RUN: begin
        if (other) begin
          st_d = EMT_ST_IDLE; // [RULE5]
          abort_d = 1'b1;
          pend_d = 1'b0;
          valid_d = 1'b0; // [RULE14]
        end else if (go || (enc_ev && !pend_q)) begin
          // Restart: earlier cycle's result is dropped
          start_d = 1'b1; // [RULE8] [RULE7]
          abort_d = 1'b1;
          by_enc_d = enc_ev && !go;
        end else if (conv.valid) begin
          st_d = EMT_ST_IDLE;
          valid_d = 1'b1; // [RULE14]
          res_d = conv.data;
          irq_d = arm_q && by_enc_q; // [RULE10] [RULE9]
        end
      end
      default: st_d = EMT_ST_IDLE;
    endcase
    if (cmd.valid && cmd.code == EMT_CMD_READ) begin
      pend_d = 1'b1;
    end
    if (st_q == EMT_ST_IDLE && other) begin
      valid_d = 1'b0;
      pend_d = 1'b0;
    end
    // Request answered only from a completed result
    if (pend_q && valid_q && st_q == EMT_ST_IDLE) begin
      reply_d.valid = 1'b1; // [RULE3] [RULE4] [RULE6]
      reply_d.data = res_q;
      // A read in the reply cycle stays pending
      pend_d = rd_req;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= EMT_ST_IDLE;
      valid_q <= 1'b0;
      res_q <= '0;
      pend_q <= 1'b0;
      arm_q <= 1'b0;
      by_enc_q <= 1'b0;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      reply <= '0;
      irq <= 1'b0;
    end else begin
      st_q <= st_d;
      valid_q <= valid_d;
      res_q <= res_d;
      pend_q <= pend_d;
      arm_q <= arm_d;
      by_enc_q <= by_enc_d;
      conv_start <= start_d;
      conv_abort <= abort_d;
      reply <= reply_d;
      irq <= irq_d;
    end
  end

  property p_no_irq_unarmed;
    @(posedge ref_clk) disable iff (!nrst) !arm_q |=> !irq;
  endproperty
  a_no_irq_unarmed: assert property (p_no_irq_unarmed) else $error("irq while unarmed"); // [RULE9]

  property p_irq_valid;
    @(posedge ref_clk) disable iff (!nrst) irq |-> valid_q && by_enc_q;
  endproperty
  a_irq_valid: assert property (p_irq_valid) else $error("irq without encode result"); // [RULE10]

  property p_abort;
    @(posedge ref_clk) disable iff (!nrst) st_q == EMT_ST_RUN && other |=> conv_abort && st_q == EMT_ST_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("cycle not aborted"); // [RULE5]

  property p_reply_valid;
    @(posedge ref_clk) disable iff (!nrst) reply.valid |-> $past(valid_q) && reply.data == $past(res_q);
  endproperty
  a_reply_valid: assert property (p_reply_valid) else $error("reply without result"); // [RULE4]

  property p_go_starts;
    @(posedge ref_clk) disable iff (!nrst) go && !other |=> conv_start;
  endproperty
  a_go_starts: assert property (p_go_starts) else $error("trigger did not start"); // [RULE2]

  property p_done_valid;
    @(posedge ref_clk) disable iff (!nrst) st_q == EMT_ST_RUN && conv.valid && !cmd.valid && !enc_ev |=> valid_q;
  endproperty
  a_done_valid: assert property (p_done_valid) else $error("result not held"); // [RULE14]

  property p_start_clears;
    @(posedge ref_clk) disable iff (!nrst) conv_start |-> !valid_q;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("valid kept over start"); // [RULE14]

  property p_enc_start;
    @(posedge ref_clk) disable iff (!nrst) enc_lvl && st_q == EMT_ST_IDLE && !cmd.valid |=> conv_start;
  endproperty
  a_enc_start: assert property (p_enc_start) else $error("encode did not start"); // [RULE1]

  // Cycle completes with no command and no restart
  sequence s_done;
    st_q == EMT_ST_RUN && conv.valid && !cmd.valid && !enc_ev;
  endsequence

  // Read while a result is held and nothing starts
  sequence s_read_idle;
    st_q == EMT_ST_IDLE && valid_q && rd_req && !enc_lvl;
  endsequence

  property p_done_reply;
    @(posedge ref_clk) disable iff (!nrst)
      s_done ##0 pend_q |=> ##1 (reply.valid && reply.data == $past(conv.data, 2));
  endproperty
  a_done_reply: assert property (p_done_reply) else $error("held read not answered"); // [RULE4]

  property p_read_idle;
    @(posedge ref_clk) disable iff (!nrst)
      s_read_idle |=> ##1 (reply.valid && reply.data == $past(res_q));
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("late read not answered"); // [RULE3] [RULE6]

  property p_irq_done;
    @(posedge ref_clk) disable iff (!nrst) s_done ##0 (arm_q && by_enc_q) |=> irq;
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("armed encode result without irq"); // [RULE10]

  property p_enc_restart;
    @(posedge ref_clk) disable iff (!nrst)
      st_q == EMT_ST_RUN && enc_ev && !pend_q && !cmd.valid |=> conv_start && conv_abort;
  endproperty
  a_enc_restart: assert property (p_enc_restart) else $error("encode did not restart"); // [RULE7] [RULE8]

  property p_arm_kept;
    @(posedge ref_clk) disable iff (!nrst) arm_q |=> arm_q;
  endproperty
  a_arm_kept: assert property (p_arm_kept) else $error("arm lost"); // [RULE9]
endmodule

//--- emt_conv_model.sv
// Converter model: answers conv_start with one conv pulse after LAT cycles.
// Assumes the control block's registered start/abort pulses; data counts starts.
`timescale 1ns/1ps
module emt_conv_model #(parameter int LAT = 5) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic conv_start,
  input wire logic conv_abort,
  output emt_pkg::emt_result_type conv
);
  import emt_pkg::*;
  int cnt;
  logic [RES_W-1:0] tag_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      tag_q <= '0;
      conv <= '0;
    end else begin
      conv.valid <= 1'b0;
      conv.data <= ~tag_q;
      if (conv_start) begin
        cnt <= LAT;
        tag_q <= tag_q + 24'h1;
      end else if (conv_abort) cnt <= 0;
      else if (cnt == 1) begin
        cnt <= 0;
        conv.valid <= 1'b1;
        conv.data <= tag_q;
      end else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule

//--- tb.sv
// Testbench for the trigger control block with a converter model.
// Assumes inputs change at falling edges; results carry the start count.
`timescale 1ns/1ps
module tb;
  import emt_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, front_n = 1'b1;
  logic [FAST_N-1:0] fast_l = '0;
  logic [OC_N-1:0] oc_l = '0;
  logic [OC_N-1:0] en = 8'hFF;
  emt_cmd_req_type cmd = '0;
  emt_result_type conv, reply;
  logic conv_start, conv_abort, irq;
  int failures = 0, comparisons = 0, nxt = 0, irqs = 0, starts = 0;
  emt_trigger_ctrl i_emt_trigger_ctrl (.ref_clk(ref_clk), .nrst(nrst), .front_encode_n(front_n),
    .backplane_fast_sync_line(fast_l), .backplane_open_collector_sync_line(oc_l), .trig_enable(en),
    .cmd(cmd), .conv(conv), .conv_start(conv_start), .conv_abort(conv_abort), .reply(reply), .irq(irq));
  emt_conv_model i_emt_conv_model (.ref_clk(ref_clk), .nrst(nrst), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv(conv));
  initial forever #5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (irq === 1'b1) irqs++;
  always @(negedge ref_clk) if (conv_start === 1'b1) starts++;
  task automatic chk(input logic [RES_W:0] s, input logic [RES_W:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic send(input emt_cmd_type c);
    @(negedge ref_clk);
    cmd = '{1'b1, c};
    if (c == EMT_CMD_GO) nxt++;
    @(negedge ref_clk);
    cmd = '0;
  endtask
  task automatic rd(input logic exp_v, input string nm);
    logic [RES_W:0] got;
    got = '0;
    send(EMT_CMD_READ);
    repeat (40) @(negedge ref_clk) if (reply.valid === 1'b1 && got[RES_W] !== 1'b1) got = reply;
    chk(got, exp_v ? {1'b1, nxt[RES_W-1:0]} : '0);
    $display("test %s done", nm);
  endtask
  task automatic enc(input int k);
    @(negedge ref_clk);
    if (k == 0) front_n = 1'b0;
    else if (k < 3) fast_l[k-1] = 1'b1;
    else oc_l[k-3] = 1'b1;
    @(negedge ref_clk);
    front_n = 1'b1;
    fast_l = '0;
    oc_l = '0;
    nxt++;
  endtask
  task automatic held_encode;
    int s0;
    s0 = starts;
    @(negedge ref_clk);
    front_n = 1'b0;
    repeat (40) @(negedge ref_clk);
    front_n = 1'b1;
    repeat (12) @(negedge ref_clk);
    chk(starts - s0 > 3, 1'b1);
    nxt = starts;
    rd(1'b1, "held_encode");
  endtask
  task automatic masked_line;
    int s0;
    s0 = starts;
    en = 8'hFE;
    enc(3);
    nxt--;
    repeat (8) @(negedge ref_clk);
    chk(starts - s0, 0);
    rd(1'b1, "masked_line");
    en = 8'hFF;
  endtask
  task automatic reset_rearm;
    int i0;
    @(negedge ref_clk);
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    nxt = 0;
    i0 = irqs;
    enc(0);
    repeat (8) @(negedge ref_clk);
    rd(1'b1, "reset_rearm");
    chk(irqs, i0);
  endtask
  task automatic test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge ref_clk);
    nrst = 1'b1;
    send(EMT_CMD_GO);
    rd(1'b1, "go_read_running");
    repeat (30) @(negedge ref_clk);
    rd(1'b1, "late_read");
    send(EMT_CMD_GO);
    send(EMT_CMD_OTHER);
    rd(1'b0, "abort");
    send(EMT_CMD_OTHER);
    enc(0);
    repeat (8) @(negedge ref_clk);
    rd(1'b1, "unarmed_encode");
    held_encode();
    chk(irqs, 0);
    send(EMT_CMD_ARM);
    for (int k = 0; k < 1 + FAST_N + OC_N; k++) begin
      enc(k);
      repeat (8) @(negedge ref_clk);
      rd(1'b1, "encode_source");
      chk(irqs, k + 1);
    end
    enc(1);
    enc(5);
    enc(0);
    repeat (8) @(negedge ref_clk);
    rd(1'b1, "multi_encode");
    send(EMT_CMD_GO);
    rd(1'b1, "armed_go");
    masked_line();
    chk(irqs, 2 + FAST_N + OC_N);
    reset_rearm();
    test_done();
  end
  initial begin
    #100us;
    failures++;
    test_done();
  end
endmodule
